// ---- core/fdp_core.sv ----
// Our own choice: the address-and-strobe port.
`timescale 1ns/1ps
`include "fdp_defs.svh"
module fdp_core
  import fdp_pkg::*;
(
  // Clock, reset, enable
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  // Register port
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  // Protection byte load from the reset sequence
  input wire fdp_prot_load_s prot_load_i,
  // ECC result words from the capture logic
  input wire logic [`FDP_ECC_WORDS-1:0][15:0] ecc_result_i,
  // Program and erase requests from the sequencer
  input wire fdp_op_s op_i,
  output logic op_ok_o,
  output logic op_refuse_o,
  // Command parameter words to the sequencer
  output logic [5:0][15:0] cmd_words_o,
  // Interrupt
  output logic irq_o
);

  ////////////////////////////////////////////////////////////////////////////
  logic [`FDP_IDX_W-1:0] cmd_idx;
  logic [`FDP_IDX_W-1:0] ecc_idx;
  logic [7:0] prot;
  logic [`FDP_ST_W-1:0] status;
  logic [`FDP_ST_W-1:0] mask;
  logic [15:0] cmd_sel_word;
  logic [15:0] ecc_sel_word;
  logic cmd_idx_ok;
  logic prot_on;
  logic op_hit;
  logic op_bad;
  logic [7:0] next_rdata;
  logic [`FDP_ST_W-1:0] st_set;
  logic [`FDP_ST_W-1:0] st_clr;

  // Byte offset into the window compared in 256-byte steps
  function automatic logic in_prot(input logic [23:0] a,
                                   input logic [`FDP_SIZE_W-1:0] n);
    logic [23:0] off;
    off = a - `FDP_DF_BASE;
    in_prot = (a >= `FDP_DF_BASE) &&
              ((off >> `FDP_SIZE_SHIFT) <= {19'h0, n});
  endfunction

  function automatic logic wr_at(input logic [7:0] ofs);
    wr_at = ce_i && wr_i && (addr_i == ofs);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  assign cmd_idx_ok = cmd_idx < `FDP_CMD_WORDS;
  assign cmd_sel_word = cmd_idx_ok ? cmd_words_o[cmd_idx] : 16'h0000;
  assign ecc_sel_word = ecc_result_i[ecc_idx];
  assign prot_on = !prot[`FDP_PROT_OPEN];
  assign op_hit = in_prot(op_i.addr, prot[`FDP_SIZE_W-1:0]);
  // Any protection covers at least the first sector, so block erase fails
  assign op_bad = prot_on &&
                  ((op_i.kind == FDP_OP_BLK_ERASE) ||
                   op_hit);

  // Index registers
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cmd_idx <= 3'h0;
      ecc_idx <= 3'h0;
    end else if (ce_i) begin
      if (wr_at(`FDP_OFS_CMD_IDX)) begin
        cmd_idx <= wdata_i[`FDP_IDX_W-1:0];
      end
      if (wr_at(`FDP_OFS_ECC_IDX)) begin
        ecc_idx <= wdata_i[`FDP_IDX_W-1:0];
      end
    end
  end

  // Command parameter array of 16-bit words, written a byte at a time; indices six and seven go nowhere
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cmd_words_o <= '0;
    end else if (ce_i && cmd_idx_ok) begin
      if (wr_at(`FDP_OFS_CMD_HI)) begin
        cmd_words_o[cmd_idx][15:8] <= wdata_i;
      end
      if (wr_at(`FDP_OFS_CMD_LO)) begin
        cmd_words_o[cmd_idx][7:0] <= wdata_i;
      end
    end
  end

  // Protection register: the reset sequence load overrides software
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prot <= `FDP_PROT_FULL;
    end else if (ce_i) begin
      if (prot_load_i.valid) begin
        prot <= prot_load_i.ok ? prot_load_i.data : `FDP_PROT_FULL;
      end else if (wr_at(`FDP_OFS_PROT)) begin
        prot <= wdata_i & `FDP_PROT_WMASK;
      end
    end
  end

  // Answer to the sequencer one cycle after the request
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      op_ok_o <= 1'b0;
      op_refuse_o <= 1'b0;
    end else if (ce_i) begin
      op_ok_o <= op_i.valid && !op_bad;
      op_refuse_o <= op_i.valid && op_bad;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Events and interrupt; a set in the clearing cycle survives
  always_comb begin
    st_set = '0;
    st_set[`FDP_ST_VIOL] = op_i.valid && op_bad;
    st_set[`FDP_ST_DONE] = op_i.valid && !op_bad;
    st_clr = wr_at(`FDP_OFS_STATUS) ? wdata_i[`FDP_ST_W-1:0] : '0;
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      status <= '0;
    end else if (ce_i) begin
      status <= (status & ~st_clr) | st_set;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mask <= '0;
    end else if (wr_at(`FDP_OFS_MASK)) begin
      mask <= wdata_i[`FDP_ST_W-1:0];
    end
  end

  // Registered, so the line follows the status by one cycle
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_o <= 1'b0;
    end else if (ce_i) begin
      irq_o <= |(status & mask);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path; unmapped offsets answer zero
  always_comb begin
    next_rdata = 8'h00;
    case (addr_i)
      `FDP_OFS_CMD_IDX: next_rdata = {5'h00, cmd_idx};
      `FDP_OFS_ECC_IDX: next_rdata = {5'h00, ecc_idx};
      `FDP_OFS_STATUS: next_rdata = {6'h00, status};
      `FDP_OFS_MASK: next_rdata = {6'h00, mask};
      `FDP_OFS_PROT: next_rdata = prot;
      `FDP_OFS_CMD_HI: next_rdata = cmd_sel_word[15:8];
      `FDP_OFS_CMD_LO: next_rdata = cmd_sel_word[7:0];
      `FDP_OFS_ECC_HI: next_rdata = ecc_sel_word[15:8];
      `FDP_OFS_ECC_LO: next_rdata = ecc_sel_word[7:0];
      default: next_rdata = 8'h00;
    endcase
  end

  // Data stand only in the cycle after the read strobe
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_o <= 8'h00;
    end else if (ce_i) begin
      rdata_o <= rd_i ? next_rdata : 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);

  property p_cmd_idx_rw;
    (wr_at(`FDP_OFS_CMD_IDX) ##1 !wr_i ##1 ce_i && rd_i && !wr_i
      && addr_i == `FDP_OFS_CMD_IDX)
    |=> rdata_o == {5'h00, $past(wdata_i[`FDP_IDX_W-1:0], 3)};
  endproperty
  a_cmd_idx_rw: assert property (p_cmd_idx_rw)
    else $error("command index readback wrong");

  property p_ecc_idx_rw;
    (wr_at(`FDP_OFS_ECC_IDX) ##1 !wr_i ##1 ce_i && rd_i && !wr_i
      && addr_i == `FDP_OFS_ECC_IDX)
    |=> rdata_o == {5'h00, $past(wdata_i[`FDP_IDX_W-1:0], 3)};
  endproperty
  a_ecc_idx_rw: assert property (p_ecc_idx_rw)
    else $error("ECC index readback wrong");

  property p_cmd_write;
    wr_at(`FDP_OFS_CMD_HI) && cmd_idx_ok
    |=> cmd_sel_word[15:8] == $past(wdata_i) && $stable(cmd_idx);
  endproperty
  a_cmd_write: assert property (p_cmd_write)
    else $error("command word byte not stored at selected index");

  property p_cmd_read;
    ce_i && rd_i && addr_i == `FDP_OFS_CMD_LO
    |=> rdata_o == $past(cmd_sel_word[7:0]);
  endproperty
  a_cmd_read: assert property (p_cmd_read)
    else $error("command word low byte read wrong");

  property p_ecc_read;
    ce_i && rd_i && addr_i == `FDP_OFS_ECC_HI
    |=> rdata_o == $past(ecc_sel_word[15:8]);
  endproperty
  a_ecc_read: assert property (p_ecc_read)
    else $error("ECC result read wrong");

  property p_load_fail;
    ce_i && prot_load_i.valid && !prot_load_i.ok
    |=> prot == `FDP_PROT_FULL && prot_on
      && prot[`FDP_SIZE_W-1:0] == '1;
  endproperty
  a_load_fail: assert property (p_load_fail)
    else $error("failed protection load not fully protected");

  property p_viol;
    ce_i && op_i.valid && prot_on && op_hit
    |=> op_refuse_o && !op_ok_o && status[`FDP_ST_VIOL];
  endproperty
  a_viol: assert property (p_viol)
    else $error("protected access not refused");

  property p_blk;
    ce_i && op_i.valid && op_i.kind == FDP_OP_BLK_ERASE && prot_on
    |=> op_refuse_o ##1 1'b1;
  endproperty
  a_blk: assert property (p_blk)
    else $error("block erase allowed while protected");

  property p_open;
    ce_i && op_i.valid && prot[`FDP_PROT_OPEN]
    |=> op_ok_o && !op_refuse_o;
  endproperty
  a_open: assert property (p_open)
    else $error("operation refused with protection open");

  property p_edge;
    ce_i && op_i.valid && prot_on && op_i.kind == FDP_OP_PROG
      && op_i.addr == `FDP_DF_BASE
        + {11'h0, prot[4:0], 8'h00} + 24'h00_0100
    |=> op_ok_o;
  endproperty
  a_edge: assert property (p_edge)
    else $error("address past protected range refused");

  property p_open_pol;
    ce_i && prot_load_i.valid && prot_load_i.ok
      && !prot_load_i.data[`FDP_PROT_OPEN]
    |=> prot_on;
  endproperty
  a_open_pol: assert property (p_open_pol)
    else $error("open bit polarity wrong");

  property p_cmd_oob_wr;
    (wr_at(`FDP_OFS_CMD_HI) || wr_at(`FDP_OFS_CMD_LO)) && !cmd_idx_ok
    |=> $stable(cmd_words_o);
  endproperty
  a_cmd_oob_wr: assert property (p_cmd_oob_wr)
    else $error("command word written past the sixth word");

  property p_cmd_oob_rd;
    ce_i && rd_i && addr_i == `FDP_OFS_CMD_HI && !cmd_idx_ok
    |=> rdata_o == 8'h00;
  endproperty
  a_cmd_oob_rd: assert property (p_cmd_oob_rd)
    else $error("command word read past the sixth word not zero");

  property p_load_ok;
    ce_i && prot_load_i.valid && prot_load_i.ok
    |=> prot == $past(prot_load_i.data);
  endproperty
  a_load_ok: assert property (p_load_ok)
    else $error("good protection load not taken");

  // Clock enable low must freeze every register of the block; this check covers all of them except op_refuse_o
  property p_ce_hold;
    !ce_i
    |=> $stable(cmd_idx) && $stable(ecc_idx) && $stable(prot)
      && $stable(status) && $stable(mask) && $stable(cmd_words_o)
      && $stable(rdata_o) && $stable(irq_o) && $stable(op_ok_o);
  endproperty
  a_ce_hold: assert property (p_ce_hold)
    else $error("state moved while clock enable low");

  property p_viol_hold;
    status[`FDP_ST_VIOL]
      && !(wr_at(`FDP_OFS_STATUS) && wdata_i[`FDP_ST_VIOL])
    |=> status[`FDP_ST_VIOL];
  endproperty
  a_viol_hold: assert property (p_viol_hold)
    else $error("violation flag lost without a clear");

  // A clear that meets a new violation in the same cycle loses
  property p_viol_clr;
    wr_at(`FDP_OFS_STATUS) && wdata_i[`FDP_ST_VIOL]
      && !(op_i.valid && op_bad)
    |=> !status[`FDP_ST_VIOL];
  endproperty
  a_viol_clr: assert property (p_viol_clr)
    else $error("violation flag not cleared by writing one");

  property p_below;
    ce_i && op_i.valid && op_i.kind != FDP_OP_BLK_ERASE
      && op_i.addr < `FDP_DF_BASE
    |=> op_ok_o && status[`FDP_ST_DONE];
  endproperty
  a_below: assert property (p_below)
    else $error("address below the protected window refused");

  property p_no_req;
    ce_i && !op_i.valid
    |=> !op_ok_o && !op_refuse_o;
  endproperty
  a_no_req: assert property (p_no_req)
    else $error("answer given without a request");

  property p_ecc_upper;
    ce_i && rd_i && addr_i == `FDP_OFS_ECC_IDX
    |=> rdata_o[7:`FDP_IDX_W] == '0;
  endproperty
  a_ecc_upper: assert property (p_ecc_upper)
    else $error("ECC index upper bits not zero");

  // The line lags the status by one cycle so it leaves a flip-flop
  property p_irq;
    ce_i |=> irq_o == |$past(status & mask);
  endproperty
  a_irq: assert property (p_irq)
    else $error("interrupt line does not follow masked status");
endmodule

// ---- core/fdp_defs.svh ----
`ifndef FDP_DEFS_SVH
`define FDP_DEFS_SVH

// Register offsets
`define FDP_OFS_CMD_IDX 8'h02
`define FDP_OFS_ECC_IDX 8'h03
`define FDP_OFS_STATUS 8'h04
`define FDP_OFS_MASK 8'h05
`define FDP_OFS_PROT 8'h06
`define FDP_OFS_CMD_HI 8'h0a
`define FDP_OFS_CMD_LO 8'h0b
`define FDP_OFS_ECC_HI 8'h0c
`define FDP_OFS_ECC_LO 8'h0d

// Fields
`define FDP_IDX_W 3
`define FDP_PROT_OPEN 7
`define FDP_SIZE_W 5
`define FDP_ST_VIOL 0
`define FDP_ST_DONE 1
`define FDP_ST_W 2

// Reset and fallback values
`define FDP_PROT_FULL 8'h1f
// Writable protection bits; software writes force bits 6 and 5 to zero
`define FDP_PROT_WMASK 8'h9f
`define FDP_CMD_WORDS 3'h6
`define FDP_ECC_WORDS 8

// Data flash window
`define FDP_DF_BASE 24'h10_0000
`define FDP_SIZE_SHIFT 8
`endif

// ---- core/fdp_pkg.sv ----
package fdp_pkg;
  typedef enum logic [1:0] {
    FDP_OP_PROG = 2'h0,
    FDP_OP_SECT_ERASE = 2'h1,
    FDP_OP_BLK_ERASE = 2'h3
  } fdp_op_e;

  typedef struct packed {
    logic valid;
    fdp_op_e kind;
    logic [23:0] addr;
  } fdp_op_s;

  typedef struct packed {
    logic valid;
    logic ok;
    logic [7:0] data;
  } fdp_prot_load_s;
endpackage

// ---- tb/fdp_tb.sv ----
`timescale 1ns/1ps
`include "fdp_defs.svh"
module tb;
  import fdp_pkg::*;
  logic clk_sys_i, rst_n_i, ce_i, wr_i, rd_i;
  logic [7:0] addr_i, wdata_i, rdata_o;
  fdp_prot_load_s prot_load_i;
  logic [`FDP_ECC_WORDS-1:0][15:0] ecc_result_i;
  fdp_op_s op_i;
  logic op_ok_o, op_refuse_o, irq_o;
  logic [5:0][15:0] cmd_words_o;
  int bad_count, n_checks;
  int ns[3] = '{0, 9, 31};
  logic [23:0] lim;

  fdp_core dut_u (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .ce_i(ce_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .prot_load_i(prot_load_i),
    .ecc_result_i(ecc_result_i), .op_i(op_i), .op_ok_o(op_ok_o),
    .op_refuse_o(op_refuse_o), .cmd_words_o(cmd_words_o), .irq_o(irq_o));

  initial begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // A gap cycle between strobes keeps each strobe a single assignment
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_sys_i);
    wr_i <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_sys_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_sys_i);
    rd_i <= 1'b0;
    #1;
    chk({8'h00, rdata_o}, {8'h00, exp});
  endtask

  task automatic op(input fdp_op_e k, input logic [23:0] a, input logic r);
    @(posedge clk_sys_i);
    op_i <= '{1'b1, k, a};
    @(posedge clk_sys_i);
    op_i.valid <= 1'b0;
    #1;
    chk({14'h0, op_ok_o, op_refuse_o}, {14'h0, ~r, r});
  endtask

  task automatic load(input logic ok, input logic [7:0] d);
    @(posedge clk_sys_i);
    prot_load_i <= '{1'b1, ok, d};
    @(posedge clk_sys_i);
    prot_load_i.valid <= 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    #100000;
    bad_count++;
    complete_run();
  end

  initial begin
    rst_n_i = 1'b0;
    ce_i = 1'b1;
    wr_i = 1'b0;
    rd_i = 1'b0;
    addr_i = 8'h00;
    wdata_i = 8'h00;
    prot_load_i = '0;
    op_i = '0;
    for (int i = 0; i < 8; i++) begin
      ecc_result_i[i] = {8'h5a ^ 8'(i), 8'h3c + 8'(i)};
    end
    repeat (5) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    rd(`FDP_OFS_PROT, 8'h1f);
    rd(`FDP_OFS_CMD_IDX, 8'h00);
    chk({15'h0, irq_o}, 16'h0000);
    // Index registers keep only their three low bits
    wr(`FDP_OFS_CMD_IDX, 8'hff);
    rd(`FDP_OFS_CMD_IDX, 8'h07);
    wr(`FDP_OFS_ECC_IDX, 8'hfa);
    rd(`FDP_OFS_ECC_IDX, 8'h02);
    wr(8'h00, 8'h55);
    rd(8'h00, 8'h00);
    // Fill all six command words, then read them back
    for (int i = 0; i < 6; i++) begin
      wr(`FDP_OFS_CMD_IDX, 8'(i));
      wr(`FDP_OFS_CMD_HI, 8'ha0 + 8'(i));
      wr(`FDP_OFS_CMD_LO, 8'h30 ^ 8'(i));
    end
    for (int i = 0; i < 6; i++) begin
      wr(`FDP_OFS_CMD_IDX, 8'(i));
      rd(`FDP_OFS_CMD_HI, 8'ha0 + 8'(i));
      rd(`FDP_OFS_CMD_LO, 8'h30 ^ 8'(i));
      chk(cmd_words_o[i], {8'ha0 + 8'(i), 8'h30 ^ 8'(i)});
    end
    wr(`FDP_OFS_CMD_IDX, 8'h06);
    wr(`FDP_OFS_CMD_HI, 8'h77);
    rd(`FDP_OFS_CMD_HI, 8'h00);
    for (int i = 0; i < 8; i++) begin
      wr(`FDP_OFS_ECC_IDX, 8'(i));
      rd(`FDP_OFS_ECC_HI, ecc_result_i[i][15:8]);
      rd(`FDP_OFS_ECC_LO, ecc_result_i[i][7:0]);
    end
    // Protection byte load from the reset sequence
    wr(`FDP_OFS_PROT, 8'hff);
    rd(`FDP_OFS_PROT, 8'h9f);
    load(1'b1, 8'h83);
    rd(`FDP_OFS_PROT, 8'h83);
    load(1'b0, 8'h83);
    rd(`FDP_OFS_PROT, 8'h1f);
    load(1'b1, 8'h05);
    rd(`FDP_OFS_PROT, 8'h05);
    op(FDP_OP_PROG, `FDP_DF_BASE + 24'h05ff, 1'b1);
    // Range edges for small, mid and largest size
    wr(`FDP_OFS_MASK, 8'h01);
    foreach (ns[j]) begin
      lim = `FDP_DF_BASE + 24'(256 * (ns[j] + 1));
      wr(`FDP_OFS_PROT, 8'(ns[j]));
      op(FDP_OP_PROG, `FDP_DF_BASE, 1'b1);
      op(FDP_OP_PROG, lim - 24'h1, 1'b1);
      op(FDP_OP_PROG, lim, 1'b0);
      op(FDP_OP_SECT_ERASE, lim - 24'h80, 1'b1);
      op(FDP_OP_SECT_ERASE, `FDP_DF_BASE - 24'h1, 1'b0);
      op(FDP_OP_BLK_ERASE, lim, 1'b1);
      wr(`FDP_OFS_PROT, 8'h80 | 8'(ns[j]));
      op(FDP_OP_PROG, `FDP_DF_BASE, 1'b0);
      op(FDP_OP_BLK_ERASE, `FDP_DF_BASE, 1'b0);
    end
    // Sticky status, mask and level interrupt
    rd(`FDP_OFS_STATUS, 8'h03);
    chk({15'h0, irq_o}, 16'h0001);
    wr(`FDP_OFS_STATUS, 8'h01);
    rd(`FDP_OFS_STATUS, 8'h02);
    chk({15'h0, irq_o}, 16'h0000);
    wr(`FDP_OFS_MASK, 8'h02);
    rd(`FDP_OFS_MASK, 8'h02);
    chk({15'h0, irq_o}, 16'h0001);
    wr(`FDP_OFS_STATUS, 8'h02);
    rd(`FDP_OFS_STATUS, 8'h00);
    chk({15'h0, irq_o}, 16'h0000);
    // Nothing is taken while the clock enable is low
    wr(`FDP_OFS_CMD_IDX, 8'h01);
    ce_i <= 1'b0;
    wr(`FDP_OFS_CMD_IDX, 8'h04);
    ce_i <= 1'b1;
    rd(`FDP_OFS_CMD_IDX, 8'h01);
    complete_run();
  end
endmodule
